/* rxd_cfg.svh */
`ifndef RXD_CFG_SVH
`define RXD_CFG_SVH

// ---------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------
`define RXD_OFF_CTRL   8'h00
`define RXD_OFF_MAP    8'h04
`define RXD_OFF_CMD    8'h08
`define RXD_OFF_STATUS 8'h0c
`define RXD_OFF_BITCNT 8'h10

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define RXD_F_MOD   0
`define RXD_F_CODE  1
`define RXD_F_DESC  4
`define RXD_F_DTYPE 5
`define RXD_F_DBYP  6
`define RXD_F_ROUTE 7
`define RXD_F_WIDE  8
`define RXD_F_MAPB  0
`define RXD_F_MAPQ  4
`define RXD_F_RESYNC 0

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define RXD_RST_CTRL 9'h000
`define RXD_RST_MAP  8'h00

// ---------------------------------------------------------------
// Puncture masks, bit p set = position p transmitted
// ---------------------------------------------------------------
`define RXD_P12_G1  7'h7f
`define RXD_P12_G2  7'h7f
`define RXD_P12_PER 3'd1
`define RXD_P34_G1  7'h03
`define RXD_P34_G2  7'h05
`define RXD_P34_PER 3'd3
`define RXD_P78_G1  7'h51
`define RXD_P78_G2  7'h2f
`define RXD_P78_PER 3'd7

// ---------------------------------------------------------------
// Descrambler taps
// ---------------------------------------------------------------
`define RXD_V35_TA 2
`define RXD_V35_TB 19
`define RXD_IBS_TA 13
`define RXD_IBS_TB 14
`define RXD_IBS_SYNC 15'h1249

`endif

/* rxd_channel_decoder.sv */
`timescale 1ns/1ps
`include "rxd_cfg.svh"
module rxd_channel_decoder
  import rxd_pkg::*;
#(
  parameter int DI_DEPTH = 8
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // AXI4-Lite register slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Soft symbols from demodulator
  input  wire logic        sym_valid,
  output logic             sym_ready,
  input  wire logic [2:0]  sym_i,
  input  wire logic [2:0]  sym_q,
  input  wire logic [5:0]  sym_wide_i,
  input  wire logic [5:0]  sym_wide_q,
  // Burst gate from receive timing
  input  wire logic        burst_active,
  // Serial outputs
  output logic             fr_data,
  output logic             fr_valid,
  output logic             ter_data,
  output logic             ter_valid
);

  if (DI_DEPTH < 1) begin : g_chk
    $error("DI_DEPTH must be at least 1");
  end

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  logic        aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q, rdata_q, bitcnt_q;
  logic [3:0]  w_strb_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [8:0]  ctrl_q, act_ctrl_q;
  logic [7:0]  map_q, act_map_q;
  logic        do_wr, resync, ibs_sync_q;
  logic [31:0] rd_word;
  logic        rd_ok;

  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready  = !w_hold_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign do_wr         = aw_hold_q && w_hold_q;
  assign resync        = do_wr && aw_addr_q == `RXD_OFF_CMD && w_strb_q[0]
                         && w_data_q[`RXD_F_RESYNC];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= (aw_addr_q == `RXD_OFF_CTRL || aw_addr_q == `RXD_OFF_MAP
                      || aw_addr_q == `RXD_OFF_CMD) ? 2'h0 : 2'h2;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Shadow settings; the decoder only sees them after a resync
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_q     <= `RXD_RST_CTRL;
      map_q      <= `RXD_RST_MAP;
      act_ctrl_q <= `RXD_RST_CTRL;
      act_map_q  <= `RXD_RST_MAP;
    end else begin
      if (do_wr && aw_addr_q == `RXD_OFF_CTRL) begin
        if (w_strb_q[0]) ctrl_q[7:0] <= w_data_q[7:0];
        if (w_strb_q[1]) ctrl_q[8] <= w_data_q[8];
      end
      if (do_wr && aw_addr_q == `RXD_OFF_MAP && w_strb_q[0]) begin
        map_q <= w_data_q[7:0];
      end
      if (resync) begin
        act_ctrl_q <= ctrl_q;
        act_map_q  <= map_q;
      end
    end
  end

  always_comb begin
    rd_ok   = 1'b1;
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      `RXD_OFF_CTRL:   rd_word[8:0] = ctrl_q;
      `RXD_OFF_MAP:    rd_word[7:0] = map_q;
      `RXD_OFF_CMD:    rd_word = 32'h0000_0000;
      `RXD_OFF_STATUS: rd_word[2:0] = {ctrl_q != act_ctrl_q || map_q != act_map_q,
                                       burst_active, ibs_sync_q};
      `RXD_OFF_BITCNT: rd_word = bitcnt_q;
      default:         rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= rd_ok ? 2'h0 : 2'h2;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Active mode decode
  // ---------------------------------------------------------------
  rxd_code_t code;
  logic      qpsk, coded, rs_on, use_qdiff, use_bdiff;
  logic [6:0] pm_g1, pm_g2;
  logic [2:0] pm_per;

  assign code  = rxd_code_t'(act_ctrl_q[`RXD_F_CODE +: 3]);
  assign qpsk  = act_ctrl_q[`RXD_F_MOD];
  assign coded = code inside {code_v12, code_v34, code_v78, code_s12,
                              code_c12, code_c34};
  assign rs_on = code inside {code_c12, code_c34};
  // Quadrature type only uncoded QPSK; biphase with uncoded BPSK or coding
  assign use_qdiff = !act_ctrl_q[`RXD_F_DBYP] && act_ctrl_q[`RXD_F_DTYPE]
                     && qpsk && !coded;
  assign use_bdiff = !act_ctrl_q[`RXD_F_DBYP] && !act_ctrl_q[`RXD_F_DTYPE]
                     && (coded || !qpsk);

  always_comb begin
    case (code)
      code_v34, code_c34: begin
        pm_g1  = `RXD_P34_G1;
        pm_g2  = `RXD_P34_G2;
        pm_per = `RXD_P34_PER;
      end
      code_v78: begin
        pm_g1  = `RXD_P78_G1;
        pm_g2  = `RXD_P78_G2;
        pm_per = `RXD_P78_PER;
      end
      default: begin
        pm_g1  = `RXD_P12_G1;
        pm_g2  = `RXD_P12_G2;
        pm_per = `RXD_P12_PER;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Input mapping and serialisation
  // ---------------------------------------------------------------
  // Map bits {swap, invert Q, invert I}; only the sign is inverted
  function automatic logic [5:0] soft_map(input logic [2:0] i, input logic [2:0] q,
                                          input logic [2:0] m);
    logic [2:0] a, b;
    a = {i[2] ^ m[0], i[1:0]};
    b = {q[2] ^ m[1], q[1:0]};
    soft_map = m[2] ? {a, b} : {b, a};
  endfunction : soft_map

  // Quadrant of a dibit in gray order, and back
  function automatic logic [1:0] quad(input logic [1:0] d);
    quad = {d[1], d[1] ^ d[0]};
  endfunction : quad

  rxd_soft_t  in_i, in_q, m_i, m_q;
  logic [2:0] map_sel;
  logic [1:0] qd_prev_q, qd_delta;
  logic [1:0] sb_cnt_q;
  rxd_soft_t  sb_q [2];
  logic       take;

  assign in_i    = act_ctrl_q[`RXD_F_WIDE] ? {sym_wide_i[5], sym_wide_i[4:3]}
                                            : sym_i;
  assign in_q    = act_ctrl_q[`RXD_F_WIDE] ? {sym_wide_q[5], sym_wide_q[4:3]}
                                            : sym_q;
  assign map_sel = qpsk ? act_map_q[`RXD_F_MAPQ +: 3]
                        : act_map_q[`RXD_F_MAPB +: 3];
  assign {m_q, m_i} = soft_map(in_i, in_q, map_sel);
  assign sym_ready  = sb_cnt_q <= 2'd1;
  assign take       = sym_valid && sym_ready;
  // Phase step between successive symbols cancels any fixed 90-degree turn
  assign qd_delta   = quad({m_i[2], m_q[2]}) - quad(qd_prev_q);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      qd_prev_q <= 2'h0;
    end else if (resync) begin
      qd_prev_q <= 2'h0;
    end else if (take) begin
      qd_prev_q <= {m_i[2], m_q[2]};
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sb_cnt_q <= 2'd0;
      sb_q[0]  <= 3'h0;
      sb_q[1]  <= 3'h0;
    end else if (resync) begin
      sb_cnt_q <= 2'd0;
    end else if (take) begin
      sb_cnt_q <= qpsk ? 2'd2 : 2'd1;
      sb_q[0]  <= use_qdiff ? {qd_delta[1], m_i[1:0]} : m_i;
      sb_q[1]  <= use_qdiff ? {qd_delta[1] ^ qd_delta[0], m_q[1:0]} : m_q;
    end else if (sb_cnt_q != 2'd0) begin
      sb_cnt_q <= sb_cnt_q - 2'd1;
      sb_q[0]  <= sb_q[1];
    end
  end

  // ---------------------------------------------------------------
  // Depuncturing and decision
  // ---------------------------------------------------------------
  logic       cb_v;
  rxd_soft_t  cb;
  logic [2:0] pp_q;
  logic       half_q;
  rxd_soft_t  g1_q;
  logic       dec_v_q, dec_b_q;

  assign cb_v = sb_cnt_q != 2'd0;
  assign cb   = sb_q[0];

  // Pair decision on summed soft values; each value weighs its magnitude plus one
  function automatic logic pair_bit(input rxd_soft_t a, input rxd_soft_t b);
    logic signed [4:0] va, vb;
    // Five bits so two full-scale values of one sign cannot wrap the sum
    va = a[2] ? -$signed({3'b000, a[1:0]}) - 5'sd1 : $signed({3'b000, a[1:0]}) + 5'sd1;
    vb = b[2] ? -$signed({3'b000, b[1:0]}) - 5'sd1 : $signed({3'b000, b[1:0]}) + 5'sd1;
    pair_bit = (va + vb) < 5'sd0;
  endfunction : pair_bit

  // Punctured position: the one symbol sent is decided alone on its sign bit
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pp_q    <= 3'd0;
      half_q  <= 1'b0;
      g1_q    <= 3'h0;
      dec_v_q <= 1'b0;
      dec_b_q <= 1'b0;
    end else if (resync) begin
      pp_q    <= 3'd0;
      half_q  <= 1'b0;
      dec_v_q <= 1'b0;
    end else begin
      dec_v_q <= 1'b0;
      if (cb_v && !coded) begin
        dec_v_q <= 1'b1;
        dec_b_q <= cb[2];
      end else if (cb_v && half_q) begin
        dec_v_q <= 1'b1;
        dec_b_q <= pair_bit(g1_q, cb);
        half_q  <= 1'b0;
        pp_q    <= (pp_q + 3'd1 == pm_per) ? 3'd0 : pp_q + 3'd1;
      end else if (cb_v && (!pm_g1[pp_q] || !pm_g2[pp_q])) begin
        dec_v_q <= 1'b1;
        dec_b_q <= cb[2];
        pp_q    <= (pp_q + 3'd1 == pm_per) ? 3'd0 : pp_q + 3'd1;
      end else if (cb_v) begin
        g1_q   <= cb;
        half_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Four-branch de-interleaver, branch b delayed (3-b) x depth
  // ---------------------------------------------------------------
  logic [1:0] com_q;
  logic [3:0] br_out;
  logic       di_v_q, di_b_q, st_v, st_b;

  for (genvar b = 0; b < 4; b++) begin : g_br
    localparam int LEN = (3 - b) * DI_DEPTH;
    if (LEN == 0) begin : g_thru
      assign br_out[b] = dec_b_q;
    end else begin : g_sr
      logic [LEN-1:0] sr_q;
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          sr_q <= '0;
        end else if (resync) begin
          sr_q <= '0;
        end else if (dec_v_q && rs_on && com_q == 2'(b)) begin
          sr_q <= LEN'({sr_q, dec_b_q});
        end
      end
      assign br_out[b] = sr_q[LEN-1];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      com_q  <= 2'd0;
      di_v_q <= 1'b0;
      di_b_q <= 1'b0;
    end else if (resync) begin
      com_q  <= 2'd0;
      di_v_q <= 1'b0;
    end else begin
      di_v_q <= dec_v_q && rs_on;
      if (dec_v_q && rs_on) begin
        di_b_q <= br_out[com_q];
        com_q  <= com_q + 2'd1;
      end
    end
  end

  assign st_v = rs_on ? di_v_q : dec_v_q;
  assign st_b = rs_on ? di_b_q : dec_b_q;

  // ---------------------------------------------------------------
  // Biphase differential decode and descrambling
  // ---------------------------------------------------------------
  logic        bd_prev_q, dd, ds, ibs_sel, pass;
  logic [19:0] v35_q;
  logic [14:0] ibs_q;

  assign dd = use_bdiff ? st_b ^ bd_prev_q : st_b;
  assign ibs_sel = act_ctrl_q[`RXD_F_DESC];
  assign ds = ibs_sel ? dd ^ ibs_q[`RXD_IBS_TA] ^ ibs_q[`RXD_IBS_TB]
                      : dd ^ v35_q[`RXD_V35_TA] ^ v35_q[`RXD_V35_TB];
  // V.35 output only flows inside a burst
  assign pass = st_v && (ibs_sel || burst_active);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bd_prev_q <= 1'b0;
    end else if (resync) begin
      bd_prev_q <= 1'b0;
    end else if (st_v) begin
      bd_prev_q <= st_b;
    end
  end

  // Fed with received bits, so the state follows the line by itself
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      v35_q <= 20'h00000;
    end else if (resync || !burst_active) begin
      v35_q <= 20'h00000;
    end else if (st_v && !ibs_sel) begin
      v35_q <= {v35_q[18:0], dd};
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ibs_q      <= 15'h0000;
      ibs_sync_q <= 1'b0;
    end else begin
      if (resync) begin
        ibs_q      <= 15'h0000;
        ibs_sync_q <= 1'b0;
      end else if (st_v && ibs_sel) begin
        ibs_q <= {ibs_q[13:0], dd};
      end
      // Set wins over the resync clear
      if (ibs_sel && ibs_q == `RXD_IBS_SYNC) begin
        ibs_sync_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Output routing
  // ---------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fr_data   <= 1'b0;
      fr_valid  <= 1'b0;
      ter_data  <= 1'b0;
      ter_valid <= 1'b0;
      bitcnt_q  <= 32'h0000_0000;
    end else begin
      fr_valid  <= pass && !act_ctrl_q[`RXD_F_ROUTE];
      ter_valid <= pass && act_ctrl_q[`RXD_F_ROUTE];
      if (pass && !act_ctrl_q[`RXD_F_ROUTE]) fr_data <= ds;
      if (pass && act_ctrl_q[`RXD_F_ROUTE]) ter_data <= ds;
      if (pass) bitcnt_q <= bitcnt_q + 32'h0000_0001;
    end
  end

endmodule : rxd_channel_decoder

/* rxd_channel_decoder_asserts.sv */
`timescale 1ns/1ps
module rxd_chk #(
  parameter int DI_DEPTH = 8
) (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Serial outputs
  input wire logic        fr_data,
  input wire logic        fr_valid,
  input wire logic        ter_data,
  input wire logic        ter_valid
);
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence wr_both_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence b_wait_s;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  wr_resp_a: assert property (wr_both_s |-> ##[1:3] s_axi_bvalid)
    else $error("write response missing");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read response missing");
  aw_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  ar_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  b_hold_a: assert property (b_wait_s |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  route_one_a: assert property (!(fr_valid && ter_valid))
    else $error("both serial outputs active");
  fr_hold_a: assert property (!fr_valid |-> $stable(fr_data))
    else $error("framing data moved without a bit");
  ter_hold_a: assert property (!ter_valid |-> $stable(ter_data))
    else $error("terrestrial data moved without a bit");
endmodule : rxd_chk

bind rxd_channel_decoder rxd_chk #(.DI_DEPTH(DI_DEPTH)) u_chk (
  .clock, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .fr_data, .fr_valid, .ter_data,
  .ter_valid
);

/* rxd_demod_model.sv */
`timescale 1ns/1ps
module rxd_demod_model (
  // Clock
  input  wire logic clock,
  // Soft symbols to decoder
  input  wire logic sym_ready,
  output logic       sym_valid,
  output logic [2:0] sym_i,
  output logic [2:0] sym_q,
  output logic [5:0] sym_wide_i,
  output logic [5:0] sym_wide_q
);
  initial begin
    sym_valid  = 1'b0;
    sym_i      = 3'h0;
    sym_q      = 3'h0;
    sym_wide_i = 6'h00;
    sym_wide_q = 6'h00;
  end
  // Released lines flip so a stale value can never pass for data
  task automatic idle();
    sym_valid  <= 1'b0;
    sym_i      <= ~sym_i;
    sym_q      <= ~sym_q;
    sym_wide_i <= ~sym_wide_i;
    sym_wide_q <= ~sym_wide_q;
  endtask : idle
  // The unused input form carries the inverse, so a wrong select shows
  task automatic send(input logic [2:0] i, input logic [2:0] q, input logic wide,
                      input int gap, output logic ok);
    logic rdy;
    ok = 1'b0;
    sym_valid  <= 1'b1;
    sym_i      <= wide ? ~i : i;
    sym_q      <= wide ? ~q : q;
    sym_wide_i <= wide ? {i, 3'h5} : ~{i, 3'h5};
    sym_wide_q <= wide ? {q, 3'h5} : ~{q, 3'h5};
    repeat (40) if (!ok) begin
      @(negedge clock);
      rdy = sym_ready;
      @(posedge clock);
      ok = rdy;
    end
    if (gap > 0) begin
      idle();
      repeat (gap) @(posedge clock);
    end
  endtask : send
endmodule : rxd_demod_model

/* rxd_pkg.sv */
package rxd_pkg;

  // Code mode, in register field order
  typedef enum logic [2:0] {
    code_unc,
    code_v12,
    code_v34,
    code_v78,
    code_s12,
    code_c12,
    code_c34
  } rxd_code_t;

  // Soft decision: sign bit then two magnitude bits
  typedef logic [2:0] rxd_soft_t;

endpackage : rxd_pkg

/* tb.sv */
`timescale 1ns/1ps
`include "rxd_cfg.svh"
module tb;
  typedef struct packed {
    logic [8:0]  ctrl;
    logic [7:0]  map;
    logic [23:0] pat;
  } rxd_row_t;
  logic        clock, rst, burst_active;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic        sym_valid, sym_ready;
  logic [2:0]  sym_i, sym_q;
  logic [5:0]  sym_wide_i, sym_wide_q;
  logic        fr_data, fr_valid, ter_data, ter_valid;
  logic        frq[$];
  logic        terq[$];
  int          n_errors;
  int          checks;
  logic [31:0] d;
  logic [1:0]  r;
  rxd_row_t    rows[13] = '{
    '{9'h040, 8'h00, 24'ha5c3f1},
    '{9'h0c0, 8'h00, 24'h3c96e1},
    '{9'h000, 8'h00, 24'hf0a55b},
    '{9'h040, 8'h01, 24'h5a3c99},
    '{9'h140, 8'h00, 24'hc3e817},
    '{9'h041, 8'h00, 24'h7e1b2d},
    '{9'h041, 8'h40, 24'h19c6f4},
    '{9'h042, 8'h00, 24'hb4d21e},
    '{9'h044, 8'h00, 24'h6ac31f},
    '{9'h046, 8'h00, 24'h8e5d27},
    '{9'h008, 8'h00, 24'h2f9c64},
    '{9'h04a, 8'h00, 24'hd3a61c},
    '{9'h04c, 8'h00, 24'h5b07e9}};

  rxd_demod_model u_demod (.clock, .sym_ready, .sym_valid, .sym_i, .sym_q,
                           .sym_wide_i, .sym_wide_q);
  rxd_channel_decoder #(.DI_DEPTH(1)) DUT (
    .clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sym_valid, .sym_ready, .sym_i,
    .sym_q, .sym_wide_i, .sym_wide_q, .burst_active, .fr_data, .fr_valid,
    .ter_data, .ter_valid);

  always #10 clock = ~clock;
  // Sampled mid-cycle: valid can stay high on successive cycles, each cycle carrying one bit
  always @(negedge clock) begin
    if (fr_valid === 1'b1) frq.push_back(fr_data);
    if (ter_valid === 1'b1) terq.push_back(ter_data);
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic hang();
    cmp(32'h0, 32'h1);
    tally_and_finish();
  endtask : hang
  task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic aw, w, b, ta, tw;
    aw = 1'b1;
    w = 1'b1;
    b = 1'b0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    repeat (50) if (!b) begin
      @(negedge clock);
      ta = aw && s_axi_awready;
      tw = w && s_axi_wready;
      b = !aw && !w && s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge clock);
      if (ta) aw = 1'b0;
      if (tw) w = 1'b0;
      s_axi_awvalid <= aw;
      s_axi_wvalid  <= w;
    end
    s_axi_bready <= 1'b0;
    if (!b) hang();
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ta, got;
    ta = 1'b0;
    got = 1'b0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    repeat (50) if (!got) begin
      @(negedge clock);
      got = ta && s_axi_rvalid;
      ta = ta || s_axi_arready;
      v = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge clock);
      s_axi_arvalid <= !ta;
    end
    s_axi_rready <= 1'b0;
    if (!got) hang();
  endtask : axi_read
  task automatic config_row(input rxd_row_t w);
    axi_write(`RXD_OFF_CTRL, {23'h0, w.ctrl}, r);
    axi_write(`RXD_OFF_MAP, {24'h0, w.map}, r);
    axi_write(`RXD_OFF_CMD, 32'h1, r);
  endtask : config_row
  task automatic send_sym(input logic b, input logic c, input rxd_row_t w);
    logic ok;
    u_demod.send({b, 2'h3}, {c, 2'h3}, w.ctrl[8], int'(w.ctrl[0]), ok);
    if (!ok) hang();
  endtask : send_sym
  // Map, optional biphase decode, then self-synchronising descramble
  function automatic logic [23:0] model_out(input rxd_row_t w);
    logic [23:0] x, y, z, p;
    logic [2:0]  mm;
    mm = w.ctrl[0] ? w.map[6:4] : w.map[2:0];
    p = w.pat;
    // Branch k%4 of the de-interleaver holds its bits back 4*(3-k%4) places
    for (int k = 0; k < 24; k++) begin
      if (w.ctrl[3:1] inside {3'd5, 3'd6}) begin
        p[k] = (k >= 12 - 4 * (k % 4)) ? w.pat[k - 12 + 4 * (k % 4)] : 1'b0;
      end
    end
    for (int k = 0; k < 24; k++) begin
      x[k] = p[(w.ctrl[0] && mm[2]) ? k ^ 1 : k] ^ mm[k % 2 & w.ctrl[0]];
      y[k] = x[k] ^ ((!w.ctrl[6] && k > 0) ? x[k - 1] : 1'b0);
      z[k] = y[k] ^ ((k >= 3) ? y[k - 3] : 1'b0) ^ ((k >= 20) ? y[k - 20] : 1'b0);
    end
    return z;
  endfunction : model_out
  // Punctured positions are sent once, kept positions twice
  task automatic stream(input rxd_row_t w, input logic chk);
    int rep, per;
    logic [23:0] gf, gt;
    frq.delete();
    terq.delete();
    per = (w.ctrl[3:1] inside {3'd2, 3'd6}) ? 3 : (w.ctrl[3:1] == 3'd3) ? 7 : 1;
    for (int k = 0; k < 24; k += 1 + w.ctrl[0]) begin
      rep = (w.ctrl[3:1] == 3'd0) ? 1 : (k % per == 0) ? 2 : 1;
      repeat (rep) send_sym(w.pat[k], w.pat[k + w.ctrl[0]], w);
    end
    u_demod.idle();
    repeat (300) if (frq.size() + terq.size() < 24) @(posedge clock);
    if (frq.size() + terq.size() < 24) hang();
    for (int k = 0; k < 24; k++) begin
      gf[k] = (k < frq.size()) ? frq[k] : 1'bx;
      gt[k] = (k < terq.size()) ? terq[k] : 1'bx;
    end
    if (chk) cmp(w.ctrl[7] ? gt : gf, model_out(w));
    if (chk) cmp(w.ctrl[7] ? frq.size() : terq.size(), 0);
  endtask : stream

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {clock, s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    burst_active = 1'b1;
    rst = 1'b1;
    n_errors = 0;
    checks = 0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    axi_read(`RXD_OFF_CTRL, d, r);
    cmp(d, `RXD_RST_CTRL);
    axi_read(`RXD_OFF_MAP, d, r);
    cmp(d, `RXD_RST_MAP);
    axi_read(8'h20, d, r);
    cmp({d[29:0], r}, 32'h2);
    axi_write(`RXD_OFF_STATUS, 32'h1, r);
    cmp(r, 2'h2);
    foreach (rows[n]) begin
      config_row(rows[n]);
      stream(rows[n], 1'b1);
    end
    // Bits outside a burst vanish; each burst starts from a clean state
    config_row(rows[0]);
    frq.delete();
    terq.delete();
    burst_active <= 1'b0;
    repeat (8) send_sym(1'b1, 1'b0, rows[0]);
    u_demod.idle();
    repeat (20) @(posedge clock);
    cmp(frq.size() + terq.size(), 0);
    burst_active <= 1'b1;
    stream(rows[0], 1'b1);
    burst_active <= 1'b0;
    repeat (3) @(posedge clock);
    burst_active <= 1'b1;
    stream(rows[0], 1'b1);
    // A new route stays pending until resync
    axi_write(`RXD_OFF_CTRL, 32'h0c0, r);
    axi_read(`RXD_OFF_STATUS, d, r);
    cmp(d[2], 1'b1);
    // A burst gap clears the descrambler so the next stream starts clean
    burst_active <= 1'b0;
    @(posedge clock);
    burst_active <= 1'b1;
    stream(rows[0], 1'b1);
    config_row('{9'h050, 8'h00, 24'h924924});
    axi_read(`RXD_OFF_STATUS, d, r);
    cmp(d[0], 1'b0);
    stream('{9'h050, 8'h00, 24'h924924}, 1'b0);
    axi_read(`RXD_OFF_STATUS, d, r);
    cmp(d[0], 1'b1);
    // Thirteen rows and four single streams of 24 bits each
    axi_read(`RXD_OFF_BITCNT, d, r);
    cmp(d, 32'd408);
    tally_and_finish();
  end
endmodule : tb
